// >>> rtl/timer_pkg.sv
// Purpose: shared constants and types for the timer compare-output block
// Assumes: byte addresses on an 8-bit AXI4-Lite address, 32-bit data
// Notes: offsets other than the first control register are local choices
`default_nettype none
package timer_pkg;
  // bus
  localparam int ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL_A = 8'h80;
  localparam logic [7:0] OFF_CTRL_B = 8'h84;
  localparam logic [7:0] OFF_CMP_A = 8'h88;
  localparam logic [7:0] OFF_CMP_B = 8'h8C;
  localparam logic [7:0] OFF_TOP = 8'h90;
  localparam logic [7:0] OFF_COUNT = 8'h94;
  localparam logic [7:0] OFF_STATUS = 8'h98;
  localparam logic [7:0] OFF_CLEAR = 8'h9C;
  localparam logic [7:0] OFF_ENABLE = 8'hA0;
  // field positions and masks
  localparam int ACT_A_LSB = 6;
  localparam int ACT_B_LSB = 4;
  localparam int MODE_LO_LSB = 0;
  localparam int MODE_HI_LSB = 3;
  localparam int CSEL_LSB = 0;
  localparam logic [7:0] CTRL_A_MASK = 8'hF3;
  localparam logic [7:0] CTRL_B_MASK = 8'h1F;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [2:0] FLAG_RST = 3'h0;
  // status bits
  localparam int ST_W = 3;
  localparam int ST_OVF = 0;
  localparam int ST_MATCH_A = 1;
  localparam int ST_MATCH_B = 2;
  // waveform modes
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_PC8 = 4'h1;
  localparam logic [3:0] MODE_PC9 = 4'h2;
  localparam logic [3:0] MODE_PC10 = 4'h3;
  localparam logic [3:0] MODE_CTC_CMP = 4'h4;
  localparam logic [3:0] MODE_FAST8 = 4'h5;
  localparam logic [3:0] MODE_FAST9 = 4'h6;
  localparam logic [3:0] MODE_FAST10 = 4'h7;
  localparam logic [3:0] MODE_PFC_REG = 4'h8;
  localparam logic [3:0] MODE_PFC_CMP = 4'h9;
  localparam logic [3:0] MODE_PC_REG = 4'hA;
  localparam logic [3:0] MODE_PC_CMP = 4'hB;
  localparam logic [3:0] MODE_CTC_REG = 4'hC;
  localparam logic [3:0] MODE_RESERVED = 4'hD;
  localparam logic [3:0] MODE_FAST_REG = 4'hE;
  localparam logic [3:0] MODE_FAST_CMP = 4'hF;
  // fixed bottom and top values
  localparam logic [15:0] BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_8 = 16'h00FF;
  localparam logic [15:0] TOP_9 = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  localparam logic [15:0] TOP_MAX = 16'hFFFF;
  // clock select codes and prescaler masks
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [9:0] PRE_DIV8 = 10'h007;
  localparam logic [9:0] PRE_DIV64 = 10'h03F;
  localparam logic [9:0] PRE_DIV256 = 10'h0FF;
  localparam logic [9:0] PRE_DIV1024 = 10'h3FF;

  typedef enum {CLS_NORMAL, CLS_CTC, CLS_FAST, CLS_PHASE, CLS_PHASE_FREQ} wave_class_e;
endpackage : timer_pkg
`default_nettype wire

// >>> rtl/timer_compare_output_control.sv
// Purpose: 16-bit timer with two compare outputs, pin override and AXI4-Lite registers
// Assumes: one clock clk_sys, synchronous active-low nrst, external count pin asynchronous
// Notes: counter is read-only; the prescaler runs free so divided ticks stay periodic
`default_nettype none
module timer_compare_output_control (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [timer_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [timer_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_clock_pin,
  output logic compare_output_a,
  output logic compare_output_b,
  output logic override_a,
  output logic override_b,
  output logic irq
);
  import timer_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [1:0][15:0] buf_cmp;
    logic [1:0][15:0] cmp;
    logic [15:0] top_reg;
    logic [15:0] cnt;
    logic up;
    logic [9:0] pre;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic [1:0] out;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] enable;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_s;

  state_s q;
  state_s d;
  logic [3:0] mode;
  wave_class_e cls;
  logic [15:0] top;
  logic tick;
  logic dual;
  logic [1:0] match;
  logic [1:0][1:0] act;
  logic [1:0] toggle_ok;
  logic [1:0] connect;
  logic wr_en;
  logic wr_known;
  logic [31:0] rd_word;
  logic rd_known;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) r[7:0] = data[7:0];
    if (strb[1]) r[15:8] = data[15:8];
    return r;
  endfunction : merge16

  assign mode = {q.ctrl_b[MODE_HI_LSB +: 2], q.ctrl_a[MODE_LO_LSB +: 2]};
  assign act[0] = q.ctrl_a[ACT_A_LSB +: 2];
  assign act[1] = q.ctrl_a[ACT_B_LSB +: 2];
  assign dual = (cls == CLS_PHASE) || (cls == CLS_PHASE_FREQ);

  // mode decode: sequence class and top source; reserved mode counts as normal
  always_comb begin
    cls = CLS_NORMAL;
    top = TOP_MAX;
    unique case (mode)
      MODE_NORMAL, MODE_RESERVED: begin
        cls = CLS_NORMAL;
        top = TOP_MAX;
      end
      MODE_PC8: begin
        cls = CLS_PHASE;
        top = TOP_8;
      end
      MODE_PC9: begin
        cls = CLS_PHASE;
        top = TOP_9;
      end
      MODE_PC10: begin
        cls = CLS_PHASE;
        top = TOP_10;
      end
      MODE_CTC_CMP: begin
        cls = CLS_CTC;
        top = q.cmp[0];
      end
      MODE_FAST8: begin
        cls = CLS_FAST;
        top = TOP_8;
      end
      MODE_FAST9: begin
        cls = CLS_FAST;
        top = TOP_9;
      end
      MODE_FAST10: begin
        cls = CLS_FAST;
        top = TOP_10;
      end
      MODE_PFC_REG: begin
        cls = CLS_PHASE_FREQ;
        top = q.top_reg;
      end
      MODE_PFC_CMP: begin
        cls = CLS_PHASE_FREQ;
        top = q.cmp[0];
      end
      MODE_PC_REG: begin
        cls = CLS_PHASE;
        top = q.top_reg;
      end
      MODE_PC_CMP: begin
        cls = CLS_PHASE;
        top = q.cmp[0];
      end
      MODE_CTC_REG: begin
        cls = CLS_CTC;
        top = q.top_reg;
      end
      MODE_FAST_REG: begin
        cls = CLS_FAST;
        top = q.top_reg;
      end
      MODE_FAST_CMP: begin
        cls = CLS_FAST;
        top = q.cmp[0];
      end
    endcase
  end

  // tick as enable only; external edges come from the synchronised pin
  always_comb begin
    tick = 1'b0;
    unique case (q.ctrl_b[CSEL_LSB +: 3])
      CS_STOP: tick = 1'b0;
      CS_DIV1: tick = 1'b1;
      CS_DIV8: tick = (q.pre & PRE_DIV8) == PRE_DIV8;
      CS_DIV64: tick = (q.pre & PRE_DIV64) == PRE_DIV64;
      CS_DIV256: tick = (q.pre & PRE_DIV256) == PRE_DIV256;
      CS_DIV1024: tick = q.pre == PRE_DIV1024;
      CS_EXT_FALL: tick = q.ext_s3 & ~q.ext_s2;
      CS_EXT_RISE: tick = ~q.ext_s3 & q.ext_s2;
    endcase
  end

  // per-channel match and pin hand-over
  always_comb begin
    for (int ch = 0; ch < 2; ch++) begin
      match[ch] = tick && (q.cnt == q.cmp[ch]);
      // PWM classes toggle only channel A, in modes 9, 11, 14 and 15; normal and CTC toggle both
      if (cls == CLS_FAST) begin
        toggle_ok[ch] = (ch == 0) && (mode == MODE_FAST_REG || mode == MODE_FAST_CMP);
      end else if (dual) begin
        toggle_ok[ch] = (ch == 0) && (mode == MODE_PFC_CMP || mode == MODE_PC_CMP);
      end else begin
        toggle_ok[ch] = 1'b1;
      end
      // action 1x takes the pin, 01 only where toggle is allowed, 00 leaves it to the port
      connect[ch] = act[ch][1] || (act[ch][0] && toggle_ok[ch]);
    end
  end

  // register read mux; unmapped or misaligned addresses answer SLVERR
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_known = 1'b1;
    unique case (s_axi_araddr)
      OFF_CTRL_A: rd_word = {24'h00_0000, q.ctrl_a};
      OFF_CTRL_B: rd_word = {24'h00_0000, q.ctrl_b};
      OFF_CMP_A: rd_word = {16'h0000, q.buf_cmp[0]};
      OFF_CMP_B: rd_word = {16'h0000, q.buf_cmp[1]};
      OFF_TOP: rd_word = {16'h0000, q.top_reg};
      OFF_COUNT: rd_word = {16'h0000, q.cnt};
      OFF_STATUS: rd_word = {29'h0000_0000, q.status};
      OFF_CLEAR: rd_word = 32'h0000_0000;
      OFF_ENABLE: rd_word = {29'h0000_0000, q.enable};
      default: rd_known = 1'b0;
    endcase
  end

  assign wr_en = q.aw_held && q.w_held && !q.bvalid;
  assign wr_known = (q.aw_addr == OFF_CTRL_A) || (q.aw_addr == OFF_CTRL_B) ||
                    (q.aw_addr == OFF_CMP_A) || (q.aw_addr == OFF_CMP_B) ||
                    (q.aw_addr == OFF_TOP) || (q.aw_addr == OFF_COUNT) ||
                    (q.aw_addr == OFF_STATUS) || (q.aw_addr == OFF_CLEAR) ||
                    (q.aw_addr == OFF_ENABLE);

  // next state: bus, prescaler, counter, buffers, waveforms, flags
  always_comb begin
    logic [ST_W-1:0] clr;
    logic [ST_W-1:0] ev;
    logic load;
    clr = '0;
    ev = '0;
    load = 1'b0;
    d = q;
    // only the second stage reads the first synchroniser flop
    d.ext_s1 = ext_clock_pin;
    d.ext_s2 = q.ext_s1;
    d.ext_s3 = q.ext_s2;
    d.pre = q.pre + 10'h001;

    // write channels taken independently, response after both
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_held = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_held = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
    if (wr_en) begin
      d.aw_held = 1'b0;
      d.w_held = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = wr_known ? RESP_OKAY : RESP_SLVERR;
      if (q.w_strb[0]) begin
        if (q.aw_addr == OFF_CTRL_A) d.ctrl_a = q.w_data[7:0] & CTRL_A_MASK;
        if (q.aw_addr == OFF_CTRL_B) d.ctrl_b = q.w_data[7:0] & CTRL_B_MASK;
        if (q.aw_addr == OFF_CLEAR) clr = q.w_data[ST_W-1:0];
        if (q.aw_addr == OFF_ENABLE) d.enable = q.w_data[ST_W-1:0];
      end
      if (q.aw_addr == OFF_CMP_A) d.buf_cmp[0] = merge16(q.buf_cmp[0], q.w_data, q.w_strb);
      if (q.aw_addr == OFF_CMP_B) d.buf_cmp[1] = merge16(q.buf_cmp[1], q.w_data, q.w_strb);
      if (q.aw_addr == OFF_TOP) d.top_reg = merge16(q.top_reg, q.w_data, q.w_strb);
    end
    if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rdata = rd_word;
      d.rresp = rd_known ? RESP_OKAY : RESP_SLVERR;
    end

    // counter steps only on a tick
    if (tick) begin
      if (dual) begin
        if (q.up) begin
          d.up = q.cnt != top;
          d.cnt = (q.cnt == top) ? q.cnt - 16'h0001 : q.cnt + 16'h0001;
        end else begin
          d.up = q.cnt == BOTTOM;
          d.cnt = (q.cnt == BOTTOM) ? q.cnt + 16'h0001 : q.cnt - 16'h0001;
        end
      end else begin
        d.up = 1'b1;
        d.cnt = (q.cnt == top) ? BOTTOM : q.cnt + 16'h0001;
      end
    end

    // buffered compare load point per class; overflow point
    unique case (cls)
      CLS_NORMAL, CLS_CTC: begin
        load = 1'b1;
        ev[ST_OVF] = tick && (q.cnt == TOP_MAX);
      end
      CLS_FAST: begin
        load = tick && (q.cnt == top);
        ev[ST_OVF] = load;
      end
      CLS_PHASE: begin
        load = tick && q.up && (q.cnt == top);
        ev[ST_OVF] = tick && !q.up && (q.cnt == BOTTOM);
      end
      CLS_PHASE_FREQ: begin
        load = tick && !q.up && (q.cnt == BOTTOM);
        ev[ST_OVF] = load;
      end
    endcase
    if (load) d.cmp = q.buf_cmp;
    ev[ST_MATCH_A] = match[0];
    ev[ST_MATCH_B] = match[1];

    // outputs hold unless an event below changes them
    for (int ch = 0; ch < 2; ch++) begin
      if (act[ch] == 2'b01) begin
        if (toggle_ok[ch] && match[ch]) d.out[ch] = ~q.out[ch];
      end else if (act[ch][1]) begin
        unique case (cls)
          CLS_NORMAL, CLS_CTC: begin
            if (match[ch]) d.out[ch] = act[ch][0];
          end
          CLS_FAST: begin
            // bottom action first, so a match at top is ignored
            if (tick && q.cnt == top) d.out[ch] = ~act[ch][0];
            else if (match[ch]) d.out[ch] = act[ch][0];
          end
          CLS_PHASE, CLS_PHASE_FREQ: begin
            if (tick && q.cmp[ch] == BOTTOM) d.out[ch] = act[ch][0];
            else if (tick && q.cmp[ch] == top) d.out[ch] = ~act[ch][0];
            else if (match[ch]) d.out[ch] = q.up ? act[ch][0] : ~act[ch][0];
          end
        endcase
      end
    end

    // sticky flags: a new event beats a clear in the same cycle
    d.status = (q.status & ~clr) | ev;
  end

  // one register stage; reset clears control and outputs together
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      q <= '0;
      q.up <= 1'b1;
      q.ctrl_a <= CTRL_RST;
      q.ctrl_b <= CTRL_RST;
      q.buf_cmp <= {VAL_RST, VAL_RST};
      q.cmp <= {VAL_RST, VAL_RST};
      q.top_reg <= VAL_RST;
      q.status <= FLAG_RST;
      q.enable <= FLAG_RST;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = !q.aw_held && !q.bvalid;
  assign s_axi_wready = !q.w_held && !q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign compare_output_a = q.out[0];
  assign compare_output_b = q.out[1];
  // the port still needs its direction bit; only the hand-over is signalled here
  assign override_a = connect[0];
  assign override_b = connect[1];
  assign irq = |(q.status & q.enable);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence pfc_bottom_tick;
    cls == CLS_PHASE_FREQ && tick && !q.up && q.cnt == BOTTOM;
  endsequence
  sequence fast_wrap_clear_a;
    cls == CLS_FAST && act[0] == 2'b10 && tick && q.cnt == top;
  endsequence

  a_tick_gates_count:
    assert property (!tick |=> q.cnt == $past(q.cnt)) else $error("counter moved without tick");
  a_pfc_bottom_load:
    assert property (pfc_bottom_tick |=> q.cmp[1] == $past(q.buf_cmp[1]))
      else $error("compare not loaded at bottom");
  a_ovf_at_bottom:
    assert property (dual && tick && !q.up && q.cnt == BOTTOM |=> q.status[ST_OVF])
      else $error("overflow flag missing at bottom");
  a_ctrl_reserved_zero:
    assert property (q.ctrl_a[3:2] == 2'b00) else $error("reserved control bits set");
  a_pin_handover:
    assert property (act[1] == 2'b10 |-> override_b) else $error("pin not handed over");
  a_idle_disconnect:
    assert property (act[0] == 2'b00 |-> !override_a) else $error("action 00 took the pin");
  a_nonpwm_set_high:
    assert property ((cls == CLS_NORMAL || cls == CLS_CTC) && act[0] == 2'b11 && match[0]
      |=> compare_output_a) else $error("set on match failed");
  a_fast_b_no_toggle:
    assert property (cls == CLS_FAST && act[1] == 2'b01 |-> !override_b)
      else $error("fast toggle reached channel B");
  a_fast_bottom_set:
    assert property (fast_wrap_clear_a |=> compare_output_a ##1 compare_output_a || tick)
      else $error("bottom set missing");
  a_fast_top_ignored:
    assert property (fast_wrap_clear_a and match[0] |=> compare_output_a)
      else $error("match at top not ignored");
  a_dual_b_no_toggle:
    assert property (dual && act[1] == 2'b01 |-> !override_b)
      else $error("dual toggle reached channel B");
  a_dual_up_clear:
    assert property (dual && act[0] == 2'b10 && match[0] && q.up && q.cmp[0] != BOTTOM
      && q.cmp[0] != top |=> !compare_output_a) else $error("up match did not clear");
  a_dual_bottom_low:
    assert property (dual && act[0] == 2'b10 && tick && q.cmp[0] == BOTTOM
      |=> !compare_output_a) else $error("bottom compare not low");
  a_reset_outputs_low:
    assert property (@(posedge clk_sys) disable iff (1'b0) !nrst |=> !compare_output_a
      && !compare_output_b && q.ctrl_a == CTRL_RST) else $error("reset left output high");
endmodule : timer_compare_output_control
`default_nettype wire

// >>> verification/port_pin_model.sv
// Purpose: model of the port pad logic behind one compare output pin
// Assumes: the pad has a pull-up that wins while the driver is off
// Notes: the port data and direction come from software via the bench
`default_nettype none
module port_pin_model (
  input wire logic port_data,
  input wire logic port_dir,
  input wire logic override,
  input wire logic cmp_out,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // pad mux; an undriven pad reads the pull-up, never a stale level
  // override picks waveform
  always_comb begin
    pin = 1'h1;
    if (port_dir) begin
      pin = override ? cmp_out : port_data;
    end
  end
endmodule : port_pin_model
`default_nettype wire

// >>> verification/testbench.sv
// Purpose: self-checking bench for the timer compare outputs
// Assumes: 10 MHz clk_sys; small top values keep periods short
// Notes: widths are counted in clk_sys cycles at prescale 1
`default_nettype none
module testbench;
  import timer_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  logic awv = 1'h0, wv = 1'h0, brdy = 1'h0, arv = 1'h0, rrdy = 1'h0, ext_pin = 1'h0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [3:0] strb = 4'hF;
  logic [31:0] wd = 32'h0, rdata, rd;
  logic awr, wrdy, bv, arr, rv, irq, ov_a, ov_b, out_a, out_b, pin_a, pin_b;
  logic [1:0] bresp, rresp, resp;
  logic [1:0] pdat = 2'h1, pdir = 2'h0;
  int num_errors = 0;
  int num_checks = 0;
  int n;

  timer_compare_output_control DUT (.clk_sys(clk_sys), .nrst(nrst),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rrdy), .ext_clock_pin(ext_pin), .compare_output_a(out_a),
    .compare_output_b(out_b), .override_a(ov_a), .override_b(ov_b), .irq(irq));
  port_pin_model pad_a (.port_data(pdat[0]), .port_dir(pdir[0]), .override(ov_a),
    .cmp_out(out_a), .pin(pin_a));
  port_pin_model pad_b (.port_data(pdat[1]), .port_dir(pdir[1]), .override(ov_b),
    .cmp_out(out_b), .pin(pin_b));

  // clock and watchdog; the whole run needs well under 20000 cycles
  always #50 clk_sys = ~clk_sys;
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    finish_test();
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // bus write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    logic ta, tw, tb;
    @(posedge clk_sys);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    brdy <= 1'h1;
    for (i = 0; i < 50; i++) begin
      // sample mid-cycle, so the edge that takes a request is not raced
      @(negedge clk_sys);
      ta = awv && awr;
      tw = wv && wrdy;
      tb = brdy && bv;
      resp = bresp;
      @(posedge clk_sys);
      if (ta) awv <= 1'h0;
      if (tw) wv <= 1'h0;
      if (tb) break;
    end
    brdy <= 1'h0;
    chk("write answer", 32'h1, 32'(i < 50));
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    int i;
    logic ta, tb;
    @(posedge clk_sys);
    ara <= a;
    arv <= 1'h1;
    rrdy <= 1'h1;
    for (i = 0; i < 50; i++) begin
      // answer taken with the values that stand before the edge
      @(negedge clk_sys);
      ta = arv && arr;
      tb = rrdy && rv;
      rd = rdata;
      resp = rresp;
      @(posedge clk_sys);
      if (ta) arv <= 1'h0;
      if (tb) break;
    end
    rrdy <= 1'h0;
    chk("read answer", 32'h1, 32'(i < 50));
  endtask : rd_reg

  function automatic logic outp(input logic b);
    return b ? out_b : out_a;
  endfunction : outp

  // length of the next whole pulse at level v; the running one is skipped
  task automatic width(input logic b, input logic v, output int w);
    int i;
    w = 0;
    // outputs are looked at mid-cycle, where they are settled
    for (i = 0; i < 3000 && outp(b) === v; i++) @(negedge clk_sys);
    for (i = 0; i < 3000 && outp(b) !== v; i++) @(negedge clk_sys);
    for (i = 0; i < 3000 && outp(b) === v; i++) begin
      @(negedge clk_sys);
      w++;
    end
  endtask : width

  task automatic hold(input string nm, input logic b, input logic v, input int c);
    repeat (c) begin
      @(negedge clk_sys);
      chk(nm, {31'h0, v}, {31'h0, outp(b)});
    end
  endtask : hold

  task automatic rst();
    @(posedge clk_sys);
    nrst <= 1'h0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'h1;
  endtask : rst

  task automatic s_regs();
    rd_reg(OFF_CTRL_A);
    chk("ctrl a reset", 32'h0, rd);
    chk("outputs reset", 32'h0, {30'h0, out_a, out_b});
    wr(OFF_CTRL_A, 32'hFF);
    rd_reg(OFF_CTRL_A);
    chk("ctrl a bits", 32'hF3, rd);
    chk("overrides on", 32'h3, {30'h0, ov_a, ov_b});
    wr(OFF_CTRL_A, 32'h0);
    pdir <= 2'h3;
    rd_reg(8'hFC);
    chk("unmapped read", 32'h2, {rd[29:0], resp});
    chk("port pins", 32'h1, {29'h0, ov_a | ov_b, pin_b, pin_a});
  endtask : s_regs

  // ctc mode 4, top = compare a = 0x10, so one period is 17 ticks
  task automatic s_ctc();
    rst();
    wr(OFF_CMP_A, 32'h10);
    wr(OFF_CMP_B, 32'h05);
    wr(OFF_CTRL_A, 32'h50);
    wr(OFF_CTRL_B, 32'h09);
    width(0, 1, n);
    chk("ctc toggle a", 32'h11, 32'(n));
    width(1, 0, n);
    chk("ctc toggle b", 32'h11, 32'(n));
    rd_reg(OFF_STATUS);
    chk("match flags", 32'h6, rd & 32'h6);
    wr(OFF_CTRL_A, 32'hA0);
    repeat (20) @(posedge clk_sys);
    hold("ctc clear", 0, 0, 20);
    wr(OFF_CTRL_A, 32'hF0);
    repeat (20) @(posedge clk_sys);
    hold("ctc set", 1, 1, 20);
  endtask : s_ctc

  // fast pwm mode 5, top 0xFF, compare 0x40 gives a 65 cycle pulse
  task automatic s_fast();
    rst();
    wr(OFF_CMP_A, 32'h40);
    wr(OFF_CTRL_A, 32'h85);
    wr(OFF_CTRL_B, 32'h09);
    width(0, 1, n);
    width(0, 1, n);
    chk("fast high", 32'h41, 32'(n));
    wr(OFF_CTRL_A, 32'hC5);
    width(0, 0, n);
    width(0, 0, n);
    chk("fast inverted", 32'h41, 32'(n));
    wr(OFF_CMP_A, 32'hFF);
    wr(OFF_CTRL_A, 32'h85);
    repeat (520) @(posedge clk_sys);
    hold("fast top", 0, 1, 260);
    wr(OFF_CTRL_A, 32'h55);
    chk("toggle mode 5", 32'h0, {30'h0, ov_a, ov_b});
    wr(OFF_CTRL_B, 32'h19);
    wr(OFF_CTRL_A, 32'h57);
    chk("toggle mode 15", 32'h2, {30'h0, ov_a, ov_b});
  endtask : s_fast

  // dual slope, top 0x20; low pulse of b spans 2 * (top - compare)
  task automatic s_dual();
    rst();
    wr(OFF_TOP, 32'h20);
    wr(OFF_CMP_A, 32'h20);
    wr(OFF_CMP_B, 32'h08);
    wr(OFF_CTRL_A, 32'h60);
    wr(OFF_CTRL_B, 32'h11);
    chk("toggle mode 8", 32'h1, {30'h0, ov_a, ov_b});
    width(1, 0, n);
    width(1, 0, n);
    chk("dual low", 32'h30, 32'(n));
    wr(OFF_CMP_B, 32'h10);
    width(1, 0, n);
    width(1, 0, n);
    chk("bottom load", 32'h20, 32'(n));
    wr(OFF_CMP_B, 32'h0);
    repeat (70) @(posedge clk_sys);
    hold("dual bottom", 1, 0, 70);
    wr(OFF_CTRL_A, 32'h51);
    chk("toggle mode 9", 32'h2, {30'h0, ov_a, ov_b});
    width(0, 1, n);
    chk("dual toggle", 32'h40, 32'(n));
    wr(OFF_ENABLE, 32'h1);
    repeat (70) @(posedge clk_sys);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(OFF_CTRL_B, 32'h10);
    wr(OFF_CLEAR, 32'h7);
    rd_reg(OFF_STATUS);
    chk("irq clear", 32'h0, {rd[30:0], irq});
  endtask : s_dual

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  // main sequence after the opening reset
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'h1;
    s_regs();
    s_ctc();
    s_fast();
    s_dual();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
